// *** design/gpc_cfg_bank.sv ***
/*
 * Configuration registers 34h..37h and the output-buffer type bit,
 * with the pin logic they steer: pin 23 polarity, power event pin
 * polarity and driver type, pin 13/14 alternate routing, pins 40-47
 * direction. Assumes the host drives cfg_* from logic on ref_clk and
 * that rstn is the standby power-on reset.
 */
module gpc_cfg_bank (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic config_state,
    input wire logic [7:0] config_index_select,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic pin23_out_val,
    input wire logic pin23_dir_out,
    input wire logic port_pin_twenty_three_in,
    output logic port_pin_twenty_three_out,
    output logic port_pin_twenty_three_oe,
    output logic pin23_in_val,
    input wire logic power_event,
    output logic power_event_out_pin_out,
    output logic power_event_out_pin_oe,
    input wire logic port_pin_thirteen_in,
    input wire logic port_pin_fourteen_in,
    output logic pin13_gpio_in,
    output logic pin14_gpio_in,
    output logic routable_irq_input_one,
    output logic routable_irq_input_two,
    input wire logic [7:0] pins_forty_out_val,
    input wire logic [7:0] port_pins_forty_to_forty_seven_in,
    output logic [7:0] port_pins_forty_to_forty_seven_out,
    output logic [7:0] port_pins_forty_to_forty_seven_oe,
    output logic [7:0] pins_forty_in_val
);
    // ==========================================================
    // register file
    logic [7:0] gpio_polarity_two;
    logic [7:0] vendor_reserved_cfg;
    logic [7:0] spare_scratch_cfg;
    logic [7:0] gpio_direction_four;
    logic [7:0] output_buffer_type_reg;
    logic [7:0] next_gpio_polarity_two;
    logic [7:0] next_vendor_reserved_cfg;
    logic [7:0] next_spare_scratch_cfg;
    logic [7:0] next_gpio_direction_four;
    logic [7:0] next_output_buffer_type_reg;
    logic [7:0] next_cfg_rdata;
    logic next_cfg_rvalid;

    function automatic logic hit(input logic [7:0] idx);
        hit = config_state && (config_index_select == idx);
    endfunction : hit

    always_comb begin
        next_gpio_polarity_two = gpio_polarity_two;
        next_vendor_reserved_cfg = vendor_reserved_cfg;
        next_spare_scratch_cfg = spare_scratch_cfg;
        next_gpio_direction_four = gpio_direction_four;
        next_output_buffer_type_reg = output_buffer_type_reg;
        next_cfg_rdata = cfg_rdata;
        next_cfg_rvalid = cfg_rd && config_state;
        if (cfg_wr) begin
            if (hit(gpc_pkg::IDX_POLARITY_TWO)) begin
                next_gpio_polarity_two = cfg_wdata;
            end
            if (hit(gpc_pkg::IDX_VENDOR_RSVD)) begin
                next_vendor_reserved_cfg = cfg_wdata;
            end
            if (hit(gpc_pkg::IDX_SCRATCH)) begin
                next_spare_scratch_cfg = cfg_wdata;
            end
            if (hit(gpc_pkg::IDX_DIRECTION_FOUR)) begin
                next_gpio_direction_four = cfg_wdata;
            end
            if (hit(gpc_pkg::IDX_OUTPUT_BUFFER)) begin
                next_output_buffer_type_reg = cfg_wdata;
            end
        end
        if (cfg_rd && config_state) begin
            unique case (config_index_select)
                gpc_pkg::IDX_POLARITY_TWO: next_cfg_rdata = gpio_polarity_two;
                gpc_pkg::IDX_VENDOR_RSVD: next_cfg_rdata = vendor_reserved_cfg;
                gpc_pkg::IDX_SCRATCH:
                    next_cfg_rdata = spare_scratch_cfg;
                gpc_pkg::IDX_DIRECTION_FOUR:
                    next_cfg_rdata = gpio_direction_four;
                gpc_pkg::IDX_OUTPUT_BUFFER:
                    next_cfg_rdata = output_buffer_type_reg;
                default: next_cfg_rdata = gpc_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gpio_polarity_two <= gpc_pkg::CFG_RESET_VALUE;
            vendor_reserved_cfg <= gpc_pkg::CFG_RESET_VALUE;
            spare_scratch_cfg <= gpc_pkg::CFG_RESET_VALUE;
            gpio_direction_four <= gpc_pkg::CFG_RESET_VALUE;
            output_buffer_type_reg <= gpc_pkg::OBUF_RESET_VALUE;
            cfg_rdata <= gpc_pkg::CFG_RESET_VALUE;
            cfg_rvalid <= 1'b0;
        end else begin
            gpio_polarity_two <= next_gpio_polarity_two;
            vendor_reserved_cfg <= next_vendor_reserved_cfg;
            spare_scratch_cfg <= next_spare_scratch_cfg;
            gpio_direction_four <= next_gpio_direction_four;
            output_buffer_type_reg <= next_output_buffer_type_reg;
            cfg_rdata <= next_cfg_rdata;
            cfg_rvalid <= next_cfg_rvalid;
        end
    end

    // ==========================================================
    // pin input synchronisers
    logic [10:0] raw_in;
    logic [10:0] sync_in;
    assign raw_in = {port_pins_forty_to_forty_seven_in,
        port_pin_fourteen_in, port_pin_thirteen_in, port_pin_twenty_three_in};

    for (genvar i = 0; i < 11; i++) begin : g_sync
        gpc_pin_sync u_sync (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .pin_in(raw_in[i]),
            .pin_sync(sync_in[i])
        );
    end

    // ==========================================================
    // pin drive
    logic pol23;
    logic pol_pme;
    logic pme_od;
    logic pme_level;
    logic next_p23_out;
    logic next_p23_oe;
    logic next_p23_in;
    logic next_pme_out;
    logic next_pme_oe;
    logic next_p13_in;
    logic next_p14_in;
    logic next_irq1;
    logic next_irq2;
    logic [7:0] next_p40_out;
    logic [7:0] next_p40_oe;
    logic [7:0] next_p40_in;

    always_comb begin
        pol23 = gpio_polarity_two[gpc_pkg::POL_PIN23_BIT];
        pol_pme = gpio_polarity_two[gpc_pkg::POL_PME_BIT];
        pme_od = output_buffer_type_reg[gpc_pkg::OBUF_PME_BIT];
        next_p23_out = pin23_out_val ^ pol23;
        next_p23_oe = pin23_dir_out;
        next_p23_in = sync_in[0] ^ pol23;
        // active-low when non-inverted
        pme_level = ~power_event ^ pol_pme;
        next_pme_out = pme_od ? 1'b0 : pme_level;
        next_pme_oe = pme_od ? ~pme_level : 1'b1;
        next_p13_in = gpio_polarity_two[gpc_pkg::ALT_PIN13_BIT] ? 1'b0
            : sync_in[1];
        next_p14_in = gpio_polarity_two[gpc_pkg::ALT_PIN14_BIT] ? 1'b0
            : sync_in[2];
        next_irq1 = gpio_polarity_two[gpc_pkg::ALT_PIN13_BIT]
            & sync_in[1];
        next_irq2 = gpio_polarity_two[gpc_pkg::ALT_PIN14_BIT]
            & sync_in[2];
        next_p40_out = pins_forty_out_val;
        next_p40_oe = gpio_direction_four;
        next_p40_in = sync_in[10:3];
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            port_pin_twenty_three_out <= 1'b0;
            port_pin_twenty_three_oe <= 1'b0;
            pin23_in_val <= 1'b0;
            power_event_out_pin_out <= 1'b0;
            power_event_out_pin_oe <= 1'b0;
            pin13_gpio_in <= 1'b0;
            pin14_gpio_in <= 1'b0;
            routable_irq_input_one <= 1'b0;
            routable_irq_input_two <= 1'b0;
            port_pins_forty_to_forty_seven_out <= '0;
            port_pins_forty_to_forty_seven_oe <= '0;
            pins_forty_in_val <= '0;
        end else begin
            port_pin_twenty_three_out <= next_p23_out;
            port_pin_twenty_three_oe <= next_p23_oe;
            pin23_in_val <= next_p23_in;
            power_event_out_pin_out <= next_pme_out;
            power_event_out_pin_oe <= next_pme_oe;
            pin13_gpio_in <= next_p13_in;
            pin14_gpio_in <= next_p14_in;
            routable_irq_input_one <= next_irq1;
            routable_irq_input_two <= next_irq2;
            port_pins_forty_to_forty_seven_out <= next_p40_out;
            port_pins_forty_to_forty_seven_oe <= next_p40_oe;
            pins_forty_in_val <= next_p40_in;
        end
    end

    // ==========================================================
    // assertions
    a_write_needs_cfg: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (!config_state && cfg_wr) |=> $stable({gpio_polarity_two,
        vendor_reserved_cfg, spare_scratch_cfg, gpio_direction_four}))
        else $error("register changed outside configuration state");
    a_pol_write_lands: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cfg_wr && config_state &&
        config_index_select == gpc_pkg::IDX_POLARITY_TWO)
        |=> gpio_polarity_two == $past(cfg_wdata))
        else $error("polarity register write lost");
    a_scratch_readback: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cfg_rd && config_state &&
        config_index_select == gpc_pkg::IDX_SCRATCH)
        |=> cfg_rvalid && cfg_rdata == $past(spare_scratch_cfg))
        else $error("scratch register read back wrong");
    a_pin23_invert: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        rstn |=> port_pin_twenty_three_out ==
        ($past(pin23_out_val) ^ $past(pol23)))
        else $error("pin 23 polarity wrong");
    a_pme_active_low: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (power_event && !pol_pme && !pme_od) |=>
        !power_event_out_pin_out && power_event_out_pin_oe)
        else $error("power event pin not driven low");
    a_pme_open_drain: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        pme_od |=> !power_event_out_pin_out)
        else $error("open drain pin driven high");
    a_irq1_route: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !gpio_polarity_two[gpc_pkg::ALT_PIN13_BIT] |=>
        !routable_irq_input_one)
        else $error("irq one active while pin is gpio");
    a_irq2_route: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !gpio_polarity_two[gpc_pkg::ALT_PIN14_BIT] |=>
        !routable_irq_input_two)
        else $error("irq two active while pin is gpio");
    a_dir_four: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        rstn |=> port_pins_forty_to_forty_seven_oe ==
        $past(gpio_direction_four))
        else $error("pins forty direction wrong");
    a_reset_clear: assert property (
        @(posedge ref_clk)
        !rstn |=> gpio_polarity_two == gpc_pkg::CFG_RESET_VALUE &&
        vendor_reserved_cfg == gpc_pkg::CFG_RESET_VALUE &&
        spare_scratch_cfg == gpc_pkg::CFG_RESET_VALUE &&
        gpio_direction_four == gpc_pkg::CFG_RESET_VALUE)
        else $error("registers not cleared by reset");
endmodule : gpc_cfg_bank

// *** design/gpc_pin_sync.sv ***
/*
 * Three-flop synchroniser for one asynchronous pin input; the output
 * changes only once the second and third stages agree.
 * Assumes ref_clk and a synchronous active-low reset.
 */
module gpc_pin_sync (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic pin_in,
    output logic pin_sync
);
    logic [gpc_pkg::SYNC_STAGES-1:0] stage;
    logic [gpc_pkg::SYNC_STAGES-1:0] next_stage;
    logic next_pin_sync;

    always_comb begin
        next_stage = {stage[gpc_pkg::SYNC_STAGES-2:0], pin_in};
        next_pin_sync = pin_sync;
        if (stage[1] == stage[2]) begin
            next_pin_sync = stage[2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stage <= '0;
            pin_sync <= 1'b0;
        end else begin
            stage <= next_stage;
            pin_sync <= next_pin_sync;
        end
    end
endmodule : gpc_pin_sync

// *** design/gpc_pkg.sv ***
/*
 * Constants for the indexed configuration bank slice of the GPIO block:
 * register indices, field positions, reset values and synchroniser depth.
 * Assumes one 100 MHz clock and an 8-bit index/data configuration port.
 */
package gpc_pkg;
    localparam logic [7:0] IDX_POLARITY_TWO = 8'h34;
    localparam logic [7:0] IDX_VENDOR_RSVD = 8'h35;
    localparam logic [7:0] IDX_SCRATCH = 8'h36;
    localparam logic [7:0] IDX_DIRECTION_FOUR = 8'h37;
    localparam logic [7:0] IDX_OUTPUT_BUFFER = 8'h39;
    localparam logic [7:0] CFG_RESET_VALUE = 8'h00;
    localparam logic [7:0] OBUF_RESET_VALUE = 8'h80;
    localparam int POL_PIN23_BIT = 3;
    localparam int POL_PME_BIT = 5;
    localparam int ALT_PIN13_BIT = 6;
    localparam int ALT_PIN14_BIT = 7;
    localparam int OBUF_PME_BIT = 7;
    localparam int SYNC_STAGES = 3;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : gpc_pkg

// *** testbench/gpc_host_model.sv ***
/*
 * Host model: indexed configuration reads and writes to the bank.
 * Assumes a shared ref_clk and that the bench calls its tasks.
 */
module gpc_host_model (
    input wire logic ref_clk,
    output logic config_state,
    output logic [7:0] config_index_select,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // access tasks
    initial begin
        config_state = 1'b0;
        config_index_select = 8'h00;
        {cfg_wr, cfg_rd} = 2'h0;
        cfg_wdata = 8'h00;
    end
    task automatic wr(input logic cs, input logic [7:0] idx,
        input logic [7:0] d);
        @(posedge ref_clk);
        config_state <= cs;
        config_index_select <= idx;
        cfg_wr <= 1'b1;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        // released data no longer shows the last value
        cfg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic cs, input logic [7:0] idx,
        output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        config_state <= cs;
        config_index_select <= idx;
        cfg_rd <= 1'b1;
        @(posedge ref_clk);
        cfg_rd <= 1'b0;
        #1;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask : rd
endmodule : gpc_host_model

// *** testbench/tb.sv ***
/*
 * Self-checking bench for the configuration bank slice.
 * Assumes gpc_host_model makes every indexed register access.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rstn, config_state, cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0] config_index_select, cfg_wdata, cfg_rdata;
    logic pin23_out_val, pin23_dir_out, port_pin_twenty_three_in;
    logic port_pin_twenty_three_out, port_pin_twenty_three_oe;
    logic pin23_in_val, power_event, power_event_out_pin_out;
    logic power_event_out_pin_oe, port_pin_thirteen_in;
    logic port_pin_fourteen_in, pin13_gpio_in, pin14_gpio_in;
    logic routable_irq_input_one, routable_irq_input_two;
    logic [7:0] pins_forty_out_val, port_pins_forty_to_forty_seven_in;
    logic [7:0] port_pins_forty_to_forty_seven_out;
    logic [7:0] port_pins_forty_to_forty_seven_oe, pins_forty_in_val;
    int error_cnt = 0;
    int total_checks = 0;

    gpc_cfg_bank i_dut (.*);
    gpc_host_model i_host (.*);

    // ========================================
    // helpers
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // {out, oe} of the power event pin
    function automatic logic [1:0] pme_exp(logic ev, logic pol, logic od);
        logic lvl;
        lvl = ~ev ^ pol;
        return od ? {1'b0, ~lvl} : {lvl, 1'b1};
    endfunction : pme_exp
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end

    // ========================================
    // tests
    initial begin
        logic [7:0] d, r, dir;
        logic v;
        rstn = 1'b0;
        {pin23_out_val, port_pin_twenty_three_in, power_event} = 3'h0;
        {port_pin_thirteen_in, port_pin_fourteen_in} = 2'h0;
        pin23_dir_out = 1'b1;
        pins_forty_out_val = 8'h00;
        port_pins_forty_to_forty_seven_in = 8'h00;
        void'($urandom(32'h7D40));
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            i_host.rd(1'b1, 8'h34 + 8'(i), r, v);
            chk(r, (i == 5) ? 8'h80 : 8'h00);
            chk({7'h00, v}, 8'h01);
        end
        for (int i = 0; i < 12; i++) begin
            d = 8'($urandom);
            r = 8'h34 + 8'(i % 4);
            if (r == 8'h35) d = 8'h00;
            i_host.wr(1'b1, r, d);
            i_host.rd(1'b1, r, dir, v);
            chk(dir, d);
        end
        i_host.wr(1'b0, 8'h37, ~d);
        i_host.rd(1'b1, 8'h37, r, v);
        chk(r, d);
        i_host.rd(1'b0, 8'h37, r, v);
        chk({7'h00, v}, 8'h00);
        i_host.wr(1'b1, 8'h3A, 8'hFF);
        i_host.rd(1'b1, 8'h3A, r, v);
        chk(r, 8'h00);
        for (int k = 0; k < 12; k++) begin
            r = 8'($urandom);
            r[5] = k[0];
            dir = 8'($urandom);
            i_host.wr(1'b1, 8'h34, r);
            i_host.wr(1'b1, 8'h39, {k[1], 7'h00});
            i_host.wr(1'b1, 8'h37, dir);
            d = 8'($urandom);
            @(posedge ref_clk);
            {port_pin_fourteen_in, port_pin_thirteen_in} <= d[4:3];
            {port_pin_twenty_three_in, pin23_out_val} <= d[2:1];
            {pin23_dir_out, power_event} <= {d[5], d[0]};
            pins_forty_out_val <= ~d;
            port_pins_forty_to_forty_seven_in <= {d[3:0], d[7:4]};
            repeat (6) @(posedge ref_clk);
            #1;
            chk({3'h0, port_pin_twenty_three_out, port_pin_twenty_three_oe,
                pin23_in_val, power_event_out_pin_out, power_event_out_pin_oe},
                {3'h0, d[1] ^ r[3], d[5], d[2] ^ r[3],
                pme_exp(d[0], r[5], k[1])});
            chk({4'h0, pin13_gpio_in, routable_irq_input_one,
                pin14_gpio_in, routable_irq_input_two},
                {4'h0, d[3] & ~r[6], d[3] & r[6],
                d[4] & ~r[7], d[4] & r[7]});
            chk(port_pins_forty_to_forty_seven_oe, dir);
            chk(port_pins_forty_to_forty_seven_out & dir, ~d & dir);
            chk(pins_forty_in_val, {d[3:0], d[7:4]});
        end
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        i_host.rd(1'b1, 8'h37, r, v);
        chk(r, 8'h00);
        final_report();
    end
endmodule : tb
